// >>> hw/efc_endpoint_fifo_regs.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
// Behaviour
// - Request bits only cleared by writes, never set
// - Interface config: mode, asynchronous_select, polarity, state, freq
// - Four 4-bit flag pin selectors, two per register
// - Restore write resets selected FIFO; NAK-all bit
// - Six polarity bits for strobes and flags
// - FIFO setup bits, reset value five
// - Auto IN length 11 or 10 bits
// - Threshold high: decision, status, speed-moved count
// - Endpoints 4/8 narrower threshold, 2-bit count
// - Iso packets per frame 1 to 3
// - Flag interrupt enables plus edge select
// - Flag interrupt requests bits 2:0 only
// - Ping-NAK enables per endpoint plus bulk summary
// - Mode field selects ports, FIFO or alternate
module efc_endpoint_fifo_regs
	import efc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	// Avalon-MM slave
	input  wire logic [15:0]      address,
	input  wire logic             read,
	input  wire logic             write,
	input  wire logic [3:0]       byteenable,
	input  wire logic [31:0]      writedata,
	output logic      [31:0]      readdata,
	output logic                  waitrequest,
	// Slave FIFO pins from the external master
	input  wire logic             packetCommitPin,
	input  wire logic             fifoOePin,
	input  wire logic             fifoReadPin,
	input  wire logic             fifoWritePin,
	input  wire logic [1:0]       fifoAddrPin,
	// FIFO core status, same clock
	input  wire logic [3:0]       flagProg,
	input  wire logic [3:0]       flagEmpty,
	input  wire logic [3:0]       flagFull,
	input  wire logic [5:0]       bulkInNak,
	input  wire logic             highSpeed,
	// Pin side outputs
	output logic      [3:0]       flagPins,
	output logic                  fifoDataOe,
	output logic      [3:0]       fifoReadPulse,
	output logic      [3:0]       fifoWritePulse,
	output logic      [3:0]       commitPulse,
	// Commands to the FIFO core
	output logic      [3:0]       forceInPulse,
	output logic      [3:0]       forceOutPulse,
	output logic                  forceSkip,
	output logic      [3:0]       fifoRestorePulse,
	output logic                  nakEveryEndpoint,
	// Configuration to the FIFO core
	output logic      [1:0]       interfaceMode,
	output logic                  asynchronousSelect,
	output logic                  interfaceClockPolarity,
	output logic                  stateOutputEnable,
	output logic                  clockSelect48,
	output logic      [3:0]       fifoWordWide,
	output logic      [3:0]       autoInCommit,
	output logic      [3:0]       autoOutCommit,
	output logic      [3:0]       zeroLengthInEnable,
	output logic      [3:0][10:0] inPacketLength,
	output logic      [3:0][2:0]  packetCount,
	output logic      [3:0][1:0]  packetsPerFrame,
	output logic      [5:0]       pingNakEnable,
	// Interrupt
	output logic                  irq
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		efc_bus_e             busState;
		logic                 waitReq;
		logic [7:0]           rdData;
		logic [0:NREG-1][7:0] regs;
		logic [5:0]           bulkReq;
		logic [3:0]           prevStrobe;
		logic [3:0]           flagPins;
		logic                 dataOe;
		logic [3:0]           rdPulse;
		logic [3:0]           wrPulse;
		logic [3:0]           cmPulse;
		logic [3:0]           inPulse;
		logic [3:0]           outPulse;
		logic                 skip;
		logic [3:0]           restorePulse;
		logic                 nak_every_endpoint;
		logic [3:0][2:0]      pktCount;
		logic                 irq;
	} efc_top_s;

	efc_top_s        st;
	efc_top_s        next_st;
	logic [5:0]      pinStable;
	logic [3:0][2:0] flagReq;
	logic [3:0][2:0] flagClear;
	logic [3:0][2:0] flagBits;
	logic [3:0]      edgeFall;
	logic [5:0]      bulkClear;
	logic [7:0]      rdValue;
	logic            hit;
	logic [5:0]      slot;
	logic [1:0]      cmdIdx;
	logic            cmdValid;
	logic [3:0]      asserted;
	logic [1:0]      addrIdx;
	logic            fifoMode;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [6:0] findSlot(input logic [15:0] a);
		logic [6:0] r;
		r = '0;
		for (int i = 0; i < NREG; i++) begin
			if (REG_INDEX[i] == a) begin
				r = {1'b1, 6'(i)};
			end
		end
		return r;
	endfunction

	// Endpoint field values 2, 4, 6 and 8 map to FIFO 0..3
	function automatic logic [2:0] endpointIdx(input logic [3:0] f);
		logic [2:0] r;
		case (f)
			4'h2: r = 3'b100;
			4'h4: r = 3'b101;
			4'h6: r = 3'b110;
			4'h8: r = 3'b111;
			default: r = 3'b000;
		endcase
		return r;
	endfunction

	// ************************************************************
	// Pins and per-endpoint flag interrupts
	// ************************************************************
	efc_pin_sync #(
		.W(6)
	) pinSync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.pinIn    ({fifoAddrPin, packetCommitPin, fifoOePin, fifoReadPin, fifoWritePin}),
		.pinStable(pinStable)
	);

	for (genvar e = 0; e < 4; e++) begin : gEp
		assign flagBits[e] = {flagProg[e], flagEmpty[e], flagFull[e]};
		assign edgeFall[e] = st.regs[SLOT_FLAGIE + e][IE_EDGE];
		efc_ep_irq epIrq (
			.clk        (clk),
			.sys_rst    (sys_rst),
			.ce         (ce),
			.flags      (flagBits[e]),
			.edgeFalling(edgeFall[e]),
			.clearBits  (flagClear[e]),
			.request    (flagReq[e])
		);
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st              = st;
		next_st.rdPulse      = '0;
		next_st.wrPulse      = '0;
		next_st.cmPulse      = '0;
		next_st.inPulse      = '0;
		next_st.outPulse     = '0;
		next_st.restorePulse = '0;
		flagClear            = '0;
		bulkClear            = '0;
		{hit, slot}          = findSlot(address);
		{cmdValid, cmdIdx}   = endpointIdx(writedata[3:0]);
		fifoMode             = st.regs[SLOT_IFCFG][1:0] == MODE_FIFO;

		// Read value; write-only and unmapped addresses read zero
		rdValue = '0;
		if (hit) begin
			rdValue = st.regs[slot];
		end
		for (int e = 0; e < 4; e++) begin
			if (address == OFS_FLAG_IRQ_EP2 + 16'(e) * OFS_FLAG_IRQ_STEP) begin
				rdValue = {5'h00, flagReq[e]};
			end
		end
		if (address == OFS_BULK_NAK_IRQ) begin
			rdValue = {2'h0, st.bulkReq};
		end

		// Bus: take the request, answer one cycle later
		case (st.busState)
			BUS_IDLE: begin
				if (read || write) begin
					next_st.busState = BUS_ANSWER;
					next_st.waitReq  = 1'b0;
					next_st.rdData   = rdValue;
				end
			end
			BUS_ANSWER: begin
				next_st.busState = BUS_IDLE;
				next_st.waitReq  = 1'b1;
				if (write && byteenable[0]) begin
					if (hit) begin
						// Read-only bits keep their reset value
						next_st.regs[slot] = (st.regs[slot] & ~REG_WMASK[slot])
							| (writedata[7:0] & REG_WMASK[slot]);
						// A zero packet count is not legal; fall back to one
						if (slot >= 6'(SLOT_ISO) && slot < 6'(SLOT_ISO + 4)
							&& writedata[1:0] == 2'h0) begin
							next_st.regs[slot][1:0] = ISO_PACKET_COUNT_MIN;
						end
					end
					if (address == OFS_FIFO_RESTORE) begin
						next_st.nak_every_endpoint = writedata[CMD_TOP_BIT];
						if (cmdValid) begin
							next_st.restorePulse[cmdIdx] = 1'b1;
						end
					end
					if (address == OFS_FORCE_IN || address == OFS_FORCE_OUT) begin
						next_st.skip = writedata[CMD_TOP_BIT];
						if (cmdValid && address == OFS_FORCE_IN) begin
							next_st.inPulse[cmdIdx] = 1'b1;
						end
						if (cmdValid && address == OFS_FORCE_OUT) begin
							next_st.outPulse[cmdIdx] = 1'b1;
						end
					end
					for (int e = 0; e < 4; e++) begin
						if (address == OFS_FLAG_IRQ_EP2 + 16'(e) * OFS_FLAG_IRQ_STEP) begin
							flagClear[e] = writedata[2:0];
						end
					end
					if (address == OFS_BULK_NAK_IRQ) begin
						bulkClear = writedata[5:0];
					end
				end
			end
			default: begin
				next_st.busState = BUS_IDLE;
				next_st.waitReq  = 1'b1;
			end
		endcase

		// Bulk NAK events; an event beats a clear in the same cycle
		next_st.bulkReq = (st.bulkReq & ~bulkClear) | bulkInNak;

		// Strobes: polarity bit high means active high
		asserted[3] = ~(pinStable[3] ^ st.regs[SLOT_POLARITY][POL_COMMIT]);
		asserted[2] = ~(pinStable[2] ^ st.regs[SLOT_POLARITY][POL_OE]);
		asserted[1] = ~(pinStable[1] ^ st.regs[SLOT_POLARITY][POL_READ]);
		asserted[0] = ~(pinStable[0] ^ st.regs[SLOT_POLARITY][POL_WRITE]);
		addrIdx            = pinStable[5:4];
		next_st.prevStrobe = asserted;
		next_st.dataOe     = fifoMode && asserted[2];
		// Strobes count only in slave FIFO mode
		if (fifoMode) begin
			next_st.cmPulse[addrIdx] = asserted[3] && !st.prevStrobe[3];
			next_st.rdPulse[addrIdx] = asserted[1] && !st.prevStrobe[1];
			next_st.wrPulse[addrIdx] = asserted[0] && !st.prevStrobe[0];
		end

		// Flag pins from their selectors, empty and full polarity applied
		for (int p = 0; p < 4; p++) begin
			logic [3:0] sel;
			logic       act;
			logic       lvl;
			sel = st.regs[SLOT_FLAGSEL + p / 2][(p % 2) * 4 +: 4];
			act = 1'b0;
			lvl = 1'b1;
			case (efc_fsel_e'(sel[3:2]))
				FSEL_PROG: begin
					act = flagProg[sel[1:0]];
				end
				FSEL_EMPTY: begin
					act = flagEmpty[sel[1:0]];
					lvl = st.regs[SLOT_POLARITY][POL_EMPTY];
				end
				FSEL_FULL: begin
					act = flagFull[sel[1:0]];
					lvl = st.regs[SLOT_POLARITY][POL_FULL];
				end
				default: begin
					act = 1'b0;
				end
			endcase
			next_st.flagPins[p] = act ? lvl : ~lvl;
		end

		// Packet count moves between registers with bus speed
		for (int e = 0; e < 4; e++) begin
			logic [7:0] hiReg;
			logic [7:0] loReg;
			hiReg = st.regs[SLOT_THRESHOLD + 2 * e];
			loReg = st.regs[SLOT_THRESHOLD + 2 * e + 1];
			if (highSpeed) begin
				next_st.pktCount[e] = hiReg[5:3];
			end else begin
				next_st.pktCount[e] = {hiReg[0], loReg[7:6]};
			end
			// Endpoints 4 and 8 carry a two-bit count
			if (e % 2 == 1) begin
				next_st.pktCount[e][2] = 1'b0;
			end
		end

		// Enabled flag requests or the bulk NAK summary raise irq
		next_st.irq = 1'b0;
		for (int e = 0; e < 4; e++) begin
			if ((flagReq[e] & st.regs[SLOT_FLAGIE + e][2:0]) != 3'h0) begin
				next_st.irq = 1'b1;
			end
		end
		if (st.regs[SLOT_PING_NAK_IRQ_ENABLE][PING_NAK_IRQ_ENABLE_BULK]
			&& (st.bulkReq & st.regs[SLOT_BULKIE][5:0]) != 6'h00) begin
			next_st.irq = 1'b1;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st          <= '0;
			st.busState <= BUS_IDLE;
			st.waitReq  <= 1'b1;
			for (int i = 0; i < NREG; i++) begin
				st.regs[i] <= REG_RESET[i];
			end
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs, all taken from flip-flops
	// ************************************************************
	assign readdata               = {24'h000000, st.rdData};
	assign waitrequest            = st.waitReq;
	assign flagPins               = st.flagPins;
	assign fifoDataOe             = st.dataOe;
	assign fifoReadPulse          = st.rdPulse;
	assign fifoWritePulse         = st.wrPulse;
	assign commitPulse            = st.cmPulse;
	assign forceInPulse           = st.inPulse;
	assign forceOutPulse          = st.outPulse;
	assign forceSkip              = st.skip;
	assign fifoRestorePulse       = st.restorePulse;
	assign nakEveryEndpoint       = st.nak_every_endpoint;
	assign interfaceMode          = st.regs[SLOT_IFCFG][1:0];
	assign asynchronousSelect     = st.regs[SLOT_IFCFG][IFCFG_ASYNCHRONOUS_SELECT];
	assign interfaceClockPolarity = st.regs[SLOT_IFCFG][IFCFG_CLKPOL];
	assign stateOutputEnable      = st.regs[SLOT_IFCFG][IFCFG_STATE];
	assign clockSelect48          = st.regs[SLOT_IFCFG][IFCFG_FREQ];
	assign packetCount            = st.pktCount;
	assign pingNakEnable          = st.regs[SLOT_PING_NAK_IRQ_ENABLE][7:2];
	assign irq                    = st.irq;

	for (genvar e = 0; e < 4; e++) begin : gCfg
		assign fifoWordWide[e]       = st.regs[SLOT_FIFOSETUP + e][SETUP_WIDE];
		assign zeroLengthInEnable[e] = st.regs[SLOT_FIFOSETUP + e][SETUP_ZLEN];
		assign autoInCommit[e]       = st.regs[SLOT_FIFOSETUP + e][SETUP_AUTO_IN_COMMIT];
		assign autoOutCommit[e]      = st.regs[SLOT_FIFOSETUP + e][SETUP_AUTOUT];
		assign inPacketLength[e]     = {st.regs[SLOT_INLEN + 2 * e][2:0],
			st.regs[SLOT_INLEN + 2 * e + 1]};
		assign packetsPerFrame[e]    = st.regs[SLOT_ISO + e][1:0];
	end

endmodule

// >>> include/efc_pkg.sv
package efc_pkg;

	// ************************************************************
	// Register table: index, reset value, writable bits
	// ************************************************************
	localparam int NREG = 40;

	// Register index; the Avalon word address equals this index
	localparam logic [15:0] REG_INDEX [0:NREG-1] = '{
		16'hE601, 16'hE602, 16'hE603, 16'hE609,
		16'hE610, 16'hE611, 16'hE612, 16'hE613, 16'hE614, 16'hE615,
		16'hE618, 16'hE619, 16'hE61A, 16'hE61B,
		16'hE620, 16'hE621, 16'hE622, 16'hE623, 16'hE624, 16'hE625, 16'hE626, 16'hE627,
		16'hE630, 16'hE631, 16'hE632, 16'hE633, 16'hE634, 16'hE635, 16'hE636, 16'hE637,
		16'hE640, 16'hE641, 16'hE642, 16'hE643,
		16'hE650, 16'hE652, 16'hE654, 16'hE656,
		16'hE658, 16'hE65A};

	localparam logic [7:0] REG_RESET [0:NREG-1] = '{
		8'h80, 8'h00, 8'h00, 8'h00,
		8'hA0, 8'hA0, 8'hA2, 8'hA0, 8'hE2, 8'hE0,
		8'h05, 8'h05, 8'h05, 8'h05,
		8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00,
		8'h88, 8'h00, 8'h88, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
		8'h01, 8'h01, 8'h01, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	// Bits outside the mask keep their reset value for good
	localparam logic [7:0] REG_WMASK [0:NREG-1] = '{
		8'hFF, 8'hFF, 8'hFF, 8'h3F,
		8'hB0, 8'hB0, 8'hFB, 8'hF0, 8'hFB, 8'hF0,
		8'h7D, 8'h7D, 8'h7D, 8'h7D,
		8'h07, 8'hFF, 8'h03, 8'hFF, 8'h07, 8'hFF, 8'h03, 8'hFF,
		8'hFB, 8'hFF, 8'hD9, 8'hFF, 8'hFB, 8'hFF, 8'hD9, 8'hFF,
		8'h83, 8'h83, 8'h83, 8'h83,
		8'h0F, 8'h0F, 8'h0F, 8'h0F,
		8'h3F, 8'hFD};

	// Slots of the table that the logic reads
	localparam int SLOT_IFCFG     = 0;
	localparam int SLOT_FLAGSEL   = 1;
	localparam int SLOT_POLARITY  = 3;
	localparam int SLOT_FIFOSETUP = 10;
	localparam int SLOT_INLEN     = 14;
	localparam int SLOT_THRESHOLD = 22;
	localparam int SLOT_ISO       = 30;
	localparam int SLOT_FLAGIE    = 34;
	localparam int SLOT_BULKIE    = 38;
	localparam int SLOT_PING_NAK_IRQ_ENABLE     = 39;

	// Registers outside the table
	localparam logic [15:0] OFS_FIFO_RESTORE  = 16'hE604;
	localparam logic [15:0] OFS_FORCE_IN      = 16'hE648;
	localparam logic [15:0] OFS_FORCE_OUT     = 16'hE649;
	localparam logic [15:0] OFS_FLAG_IRQ_EP2  = 16'hE651;
	localparam logic [15:0] OFS_FLAG_IRQ_STEP = 16'h0002;
	localparam logic [15:0] OFS_BULK_NAK_IRQ  = 16'hE659;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int IFCFG_ASYNCHRONOUS_SELECT  = 3;
	localparam int IFCFG_CLKPOL = 4;
	localparam int IFCFG_STATE  = 2;
	localparam int IFCFG_FREQ   = 6;
	localparam int POL_COMMIT   = 5;
	localparam int POL_OE       = 4;
	localparam int POL_READ     = 3;
	localparam int POL_WRITE    = 2;
	localparam int POL_EMPTY    = 1;
	localparam int POL_FULL     = 0;
	localparam int SETUP_WIDE   = 0;
	localparam int SETUP_ZLEN   = 2;
	localparam int SETUP_AUTO_IN_COMMIT = 3;
	localparam int SETUP_AUTOUT = 4;
	localparam int IE_EDGE      = 3;
	localparam int CMD_TOP_BIT  = 7;
	localparam int PING_NAK_IRQ_ENABLE_BULK   = 0;

	localparam logic [1:0] ISO_PACKET_COUNT_MIN = 2'h1;

	// ************************************************************
	// Enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_PORTS   = 2'b00,
		MODE_RESVD   = 2'b01,
		MODE_ALT     = 2'b10,
		MODE_FIFO    = 2'b11
	} efc_mode_e;

	// Flag pin select: upper two bits pick the flag kind, lower two the endpoint
	typedef enum logic [1:0] {
		FSEL_OFF     = 2'b00,
		FSEL_PROG    = 2'b01,
		FSEL_EMPTY   = 2'b10,
		FSEL_FULL    = 2'b11
	} efc_fsel_e;

	typedef enum logic [1:0] {
		BUS_IDLE     = 2'b00,
		BUS_ANSWER   = 2'b01
	} efc_bus_e;

endpackage

// >>> hw/efc_pin_sync.sv
`timescale 1ns/100ps
module efc_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	// Pins and filtered result
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinStable
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} efc_sync_s;

	efc_sync_s st;
	efc_sync_s next_st;

	// A bit moves only once the second and third stage agree
	always_comb begin
		next_st    = st;
		next_st.s1 = pinIn;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.stable[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign pinStable = st.stable;

endmodule

// >>> hw/efc_ep_irq.sv
`timescale 1ns/100ps
module efc_ep_irq (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	// Flags {programmable, empty, full}, active high
	input  wire logic [2:0] flags,
	input  wire logic       edgeFalling,
	// Write-one-to-clear and request bits
	input  wire logic [2:0] clearBits,
	output logic      [2:0] request
);

	typedef struct packed {
		logic [2:0] prev;
		logic [2:0] req;
	} efc_irq_s;

	efc_irq_s   st;
	efc_irq_s   next_st;
	logic [2:0] event3;

	always_comb begin
		next_st      = st;
		event3       = flags & ~st.prev;
		// Programmable flag may trigger on its falling edge instead
		if (edgeFalling) begin
			event3[2] = ~flags[2] & st.prev[2];
		end
		next_st.prev = flags;
		// Set wins over a clear in the same cycle; writes only clear
		next_st.req  = (st.req & ~clearBits) | event3;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign request = st.req;

endmodule

// >>> sim/efc_fifo_master.sv
`timescale 1ns/100ps
module efc_fifo_master (
	// Clock and active levels {commit, oe, read, write}
	input  wire logic       clk,
	input  wire logic [3:0] actLevel,
	// Strobes and address to the device
	output logic            packetCommitPin,
	output logic            fifoOePin,
	output logic            fifoReadPin,
	output logic            fifoWritePin,
	output logic      [1:0] fifoAddrPin
);
	logic [3:0] on = 4'h0;
	logic [3:0] pins;

	initial fifoAddrPin = 2'h0;
	// Idle pins sit at the inactive level, never a stale active one
	assign pins = actLevel ^ ~on;
	assign packetCommitPin = pins[3];
	assign fifoOePin = pins[2];
	assign fifoReadPin = pins[1];
	assign fifoWritePin = pins[0];

	// Address settles a cycle ahead; gap of 4 keeps strobes apart
	task strobe(input int k, input logic [1:0] a, input int len);
		@(posedge clk);
		fifoAddrPin <= a;
		@(posedge clk);
		on[k] <= 1'b1;
		repeat (len) @(posedge clk);
		on[k] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// >>> sim/efc_regs_asserts.sv
`timescale 1ns/100ps
module efc_regs_asserts
	import efc_pkg::*;
(
	// Bus
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic             ce,
	input wire logic [15:0]      address,
	input wire logic             read,
	input wire logic             write,
	input wire logic [3:0]       byteenable,
	input wire logic [31:0]      writedata,
	input wire logic [31:0]      readdata,
	input wire logic             waitrequest,
	// Side outputs
	input wire logic [1:0]       interfaceMode,
	input wire logic             fifoDataOe,
	input wire logic [3:0]       fifoReadPulse,
	input wire logic [3:0]       fifoRestorePulse,
	input wire logic [3:0]       forceInPulse,
	input wire logic [3:0]       forceOutPulse,
	input wire logic             forceSkip,
	input wire logic             nakEveryEndpoint,
	input wire logic [3:0][10:0] inPacketLength,
	input wire logic [3:0][2:0]  packetCount,
	input wire logic [3:0][1:0]  packetsPerFrame
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	function automatic logic [4:0] hot(input logic [31:0] w);
		return {w[7], w[3:0] == 4'h8, w[3:0] == 4'h6, w[3:0] == 4'h4, w[3:0] == 4'h2};
	endfunction

	sequence s_wr(a);
		write && !waitrequest && byteenable[0] && address == a;
	endsequence
	sequence s_rd(a);
		read && !waitrequest && address == a;
	endsequence

	property p_ack;
		(read || write) && waitrequest && ce ##1 ce |-> !waitrequest;
	endproperty
	property p_one;
		$fell(waitrequest) |=> waitrequest;
	endproperty
	property p_hi;
		!waitrequest |-> readdata[31:8] == 24'h0;
	endproperty
	property p_rst;
		s_wr(OFS_FIFO_RESTORE) |=> {nakEveryEndpoint, fifoRestorePulse} == hot($past(writedata))
			##1 fifoRestorePulse == 4'h0;
	endproperty
	property p_fin;
		s_wr(OFS_FORCE_IN) |=> {forceSkip, forceInPulse} == hot($past(writedata));
	endproperty
	property p_fout;
		s_wr(OFS_FORCE_OUT) |=> {forceSkip, forceOutPulse} == hot($past(writedata));
	endproperty
	property p_wo;
		s_rd(OFS_FIFO_RESTORE) or s_rd(OFS_FORCE_OUT) |-> readdata == 32'h0;
	endproperty
	property p_str;
		|fifoReadPulse |-> $onehot(fifoReadPulse) && $past(interfaceMode) == MODE_FIFO;
	endproperty
	property p_oe;
		fifoDataOe |-> $past(interfaceMode) == MODE_FIFO;
	endproperty
	property p_len;
		inPacketLength[1][10] == 1'b0 && inPacketLength[3][10] == 1'b0
			&& packetCount[1][2] == 1'b0 && packetCount[3][2] == 1'b0;
	endproperty
	property p_ppf;
		packetsPerFrame[0] != 2'h0 && packetsPerFrame[1] != 2'h0
			&& packetsPerFrame[2] != 2'h0 && packetsPerFrame[3] != 2'h0;
	endproperty

	a_ack: assert property (p_ack) else $error("access not answered");
	a_one: assert property (p_one) else $error("ack longer than one cycle");
	a_hi: assert property (p_hi) else $error("upper read bits set");
	a_rst: assert property (p_rst) else $error("restore pulse wrong");
	a_fin: assert property (p_fin) else $error("force in pulse wrong");
	a_fout: assert property (p_fout) else $error("force out pulse wrong");
	a_wo: assert property (p_wo) else $error("write-only read nonzero");
	a_str: assert property (p_str) else $error("read pulse outside fifo mode");
	a_oe: assert property (p_oe) else $error("data enable outside fifo mode");
	a_len: assert property (p_len) else $error("narrow endpoint field set");
	a_ppf: assert property (p_ppf) else $error("packets per frame zero");
endmodule

bind efc_endpoint_fifo_regs efc_regs_asserts u_asserts (.*);

// >>> sim/efc_endpoint_fifo_regs_tb.sv
`timescale 1ns/100ps
module efc_endpoint_fifo_regs_tb
	import efc_pkg::*;
();
	// ****
	// Stimulus and observed signals
	// ****
	logic clk = 0, sys_rst = 1, ce = 1, read = 0, write = 0, highSpeed = 0, irq;
	logic [15:0] address = 0;
	logic [31:0] writedata = 0, readdata;
	logic [3:0] byteenable = 4'hF, flagProg = 0, flagEmpty = 0, flagFull = 0, actLevel = 0;
	logic [5:0] bulkInNak = 0;
	logic waitrequest, fifoDataOe, forceSkip, nakEveryEndpoint;
	logic packetCommitPin, fifoOePin, fifoReadPin, fifoWritePin;
	logic [1:0] fifoAddrPin, interfaceMode, a;
	logic [3:0] fifoReadPulse, fifoWritePulse, commitPulse, forceInPulse, forceOutPulse;
	logic [3:0] fifoRestorePulse;
	logic [7:0] q, d, e;
	logic [4:0] got;
	logic [3:0] flagPins;
	logic [3:0][2:0] packetCount;
	logic [7:0] cmds [5] = '{8'h02, 8'h84, 8'h06, 8'h88, 8'h85};
	int err_total = 0, compares = 0, cyc = 0;

	efc_endpoint_fifo_regs uut (.*, .asynchronousSelect(),
		.interfaceClockPolarity(), .stateOutputEnable(), .clockSelect48(), .fifoWordWide(),
		.autoInCommit(), .autoOutCommit(), .zeroLengthInEnable(), .inPacketLength(),
		.packetsPerFrame(), .pingNakEnable());
	efc_fifo_master mst (.*);

	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test;
		end
	end

	// ****
	// Tasks
	// ****
	task stop_test;
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask

	// Request held until waitrequest is seen low; answer taken there
	task av(input logic w, input logic [15:0] ad, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		address <= ad;
		write <= w;
		read <= !w;
		writedata <= {24'h0, wd};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		if (n >= 40) err_total++;
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task rst;
		sys_rst <= 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
	endtask

	task waitChk(input string n, input logic x);
		repeat (2) @(posedge clk);
		#1;
		chk(n, x, irq);
	endtask

	// ORs every pulse of the kind chosen by k over a 12-cycle window, so a missing or misrouted pulse shows
	task pchk(input int k, input logic [3:0] x);
		logic [3:0] s;
		s = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			s = s | (k == 0 ? fifoWritePulse : k == 1 ? fifoReadPulse : commitPulse);
		end
		chk("pulse", x, s);
	endtask

	function automatic logic [3:0] epHot(input logic [3:0] p);
		return {p == 4'h8, p == 4'h6, p == 4'h4, p == 4'h2};
	endfunction

	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'h0F80));
		rst;
		for (int i = 0; i < NREG; i++) begin
			av(0, REG_INDEX[i], 8'h00);
			chk("reset", REG_RESET[i], q);
		end
		// Writes stay within the table
		for (int i = 0; i < NREG; i++) begin
			d = $urandom;
			e = (REG_RESET[i] & ~REG_WMASK[i]) | (d & REG_WMASK[i]);
			if (i >= SLOT_ISO && i < SLOT_ISO + 4 && e[1:0] == 2'b00) e[0] = 1'b1;
			av(1, REG_INDEX[i], d);
			av(0, REG_INDEX[i], 8'h00);
			chk("rw", e, q);
		end
		av(1, 16'hE640, 8'h80);
		// Enable low holds the read off for three cycles
		fork
			av(0, 16'hE640, 8'h00);
			begin
				@(posedge clk);
				ce <= 1'b0;
				repeat (3) @(posedge clk);
				ce <= 1'b1;
			end
		join
		chk("iso", 8'h81, q);
		av(1, 16'hE605, 8'hFF);
		av(0, 16'hE605, 8'h00);
		chk("unmapped", 8'h00, q);
		av(0, OFS_FIFO_RESTORE, 8'h00);
		chk("wo", 8'h00, q);
		av(0, OFS_FORCE_OUT, 8'h00);
		chk("wo", 8'h00, q);
		rst;
		av(0, 16'hE601, 8'h00);
		chk("rereset", 8'h80, q);
		highSpeed <= 1'b1;
		repeat (2) @(posedge clk);
		chk("packet_count", 3'h1, packetCount[0]);
		highSpeed <= 1'b0;
		foreach (cmds[j]) for (int k = 0; k < 3; k++) begin
			av(1, k == 0 ? OFS_FIFO_RESTORE : OFS_FORCE_IN + 16'(k - 1), cmds[j]);
			#1;
			got = k == 0 ? {nakEveryEndpoint, fifoRestorePulse} :
				k == 1 ? {forceSkip, forceInPulse} : {forceSkip, forceOutPulse};
			chk("cmd", {cmds[j][7], epHot(cmds[j][3:0])}, got);
		end
		// Endpoint 4 empty rises too but stays masked
		av(1, 16'hE650, 8'h02);
		flagEmpty <= 4'h3;
		waitChk("irq", 1'b1);
		av(1, 16'hE602, 8'hC8);
		av(1, 16'hE651, 8'h02);
		chk("pins", 2'h2, flagPins[1:0]);
		waitChk("irq", 1'b0);
		av(1, 16'hE651, 8'h07);
		av(0, 16'hE651, 8'h00);
		chk("req2", 8'h00, q);
		av(0, 16'hE653, 8'h00);
		chk("req4", 8'h02, q);
		av(1, 16'hE652, 8'h02);
		waitChk("irq", 1'b1);
		av(1, 16'hE653, 8'h02);
		waitChk("irq", 1'b0);
		av(1, 16'hE658, 8'h01);
		av(1, 16'hE65A, 8'h01);
		bulkInNak <= 6'h01;
		@(posedge clk);
		bulkInNak <= 6'h00;
		@(posedge clk);
		#1;
		chk("irq", 1'b1, irq);
		av(1, 16'hE659, 8'h01);
		av(0, 16'hE659, 8'h00);
		chk("bulk", 8'h00, q);
		// Falling edge select: a rising programmable flag stays quiet
		av(1, 16'hE650, 8'h0C);
		flagProg <= 4'h1;
		waitChk("irq", 1'b0);
		@(posedge clk);
		flagProg <= 4'h0;
		waitChk("irq", 1'b1);
		// Fifo mode, output enable active low, other strobes active high
		av(1, 16'hE601, 8'h83);
		av(1, 16'hE609, 8'h2C);
		actLevel <= 4'b1011;
		#1;
		chk("mode", MODE_FIFO, interfaceMode);
		repeat (8) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			a = $urandom;
			if (k != 2) fork
				mst.strobe(k, a, 2 + $urandom % 6);
				pchk(k, 4'h1 << a);
			join
		end
		fork
			mst.strobe(2, 2'h0, 10);
			begin
				repeat (8) @(posedge clk);
				#1;
				chk("oe", 1'b1, fifoDataOe);
			end
		join
		av(1, 16'hE601, 8'h80);
		fork
			mst.strobe(1, 2'h2, 3);
			pchk(1, 4'h0);
		join
		stop_test;
	end
endmodule
